/* verilog/mtx_top.sv */
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
module mtx_top #(
  parameter int SLOT_CYCLES = mtx_pkg::SLOT_CYCLES,
  parameter int SLOT_W      = 16
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        eng_done,
  input  wire logic        eng_collision,
  input  wire logic        eng_underrun,
  input  wire logic        carrier_sense,
  input  wire logic        cd_heartbeat,
  input  wire logic        mc_hash_valid,
  input  wire logic [5:0]  mc_hash_index,
  output logic             tx_attempt,
  output logic             tx_abort,
  output logic             crc_append,
  output logic      [1:0]  loop_mode,
  output logic             codec_loop_pin,
  output logic             loopback_active,
  output logic             tx_enabled
);

  typedef struct packed {
    mtx_pkg::mtx_state_t state;
    logic [7:0]          cfg;
    logic                loop_select_n;
    logic [7:0]          status;
    logic [4:0]          ncoll;
    logic [4:0]          attempts;
    logic                pending;
    logic                past_slot;
    logic [SLOT_W-1:0]   slot_cnt;
    logic                cd_seen;
    logic                tx_en;
    logic                ack;
    logic [31:0]         dat;
    logic                attempt;
    logic                abort;
    logic                crc_app;
    logic                codec_pin;
    logic                lb_active;
  } mtx_top_t;

  localparam logic [SLOT_W-1:0] SLOT_LAST = SLOT_W'(SLOT_CYCLES - 1);
  localparam logic [9:0] HB_LOAD = 10'(mtx_pkg::HB_CYCLES);
  localparam logic [4:0] ATT_MAX = 5'(mtx_pkg::MAX_ATTEMPTS);

  mtx_top_t   st_reg;
  mtx_top_t   st_next;
  logic       req;
  logic [5:0] idx;
  logic       slot_tick;
  logic       bo_load;
  logic       hb_load;
  logic       bo_zero;
  logic       hb_zero;
  logic [9:0] bo_slots;

  // ----------------------------------------------------------------------
  // Backoff draw and wait timers
  // ----------------------------------------------------------------------
  mtx_backoff u_backoff (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .coll_num (st_reg.attempts),
    .prio_en  (st_reg.cfg[mtx_pkg::CFG_PRIORITY_BACKOFF_ENABLE]),
    .slots    (bo_slots)
  );

  mtx_timer #(.W(10)) u_bo_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .load     (bo_load),
    .load_val (bo_slots),
    .tick     (slot_tick),
    .zero     (bo_zero)
  );

  mtx_timer #(.W(10)) u_hb_timer (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .load     (hb_load),
    .load_val (HB_LOAD),
    .tick     (1'b1),
    .zero     (hb_zero)
  );

  assign req       = wb_cyc_i && wb_stb_i && !st_reg.ack;
  assign idx       = wb_adr_i[7:2];
  assign slot_tick = (st_reg.slot_cnt == SLOT_LAST);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    st_next         = st_reg;
    st_next.attempt = 1'b0;
    st_next.abort   = 1'b0;
    st_next.ack     = req;
    bo_load         = 1'b0;
    hb_load         = 1'b0;

    // Slot divider, restarted at each attempt and each backoff.
    if (slot_tick)
    begin
      st_next.slot_cnt = '0;
    end
    else
    begin
      st_next.slot_cnt = st_reg.slot_cnt + SLOT_W'(1);
    end

    // Register reads; write-only and unmapped words read as zero.
    st_next.dat = 32'h0000_0000;
    if (req && !wb_we_i)
    begin
      if (idx == mtx_pkg::IDX_STATUS)
      begin
        st_next.dat[7:0] = st_reg.status;
      end
      else if (idx == mtx_pkg::IDX_NCOLL)
      begin
        st_next.dat[4:0] = st_reg.ncoll;
      end
      else if (idx == mtx_pkg::IDX_DCFG)
      begin
        st_next.dat[mtx_pkg::DCFG_LS] = st_reg.loop_select_n;
      end
      else if (idx == mtx_pkg::IDX_CTRL)
      begin
        st_next.dat[mtx_pkg::CTRL_BUSY] =
          (st_reg.state != mtx_pkg::MTX_IDLE);
        st_next.dat[mtx_pkg::CTRL_EN]   = st_reg.tx_en;
        st_next.dat[mtx_pkg::CTRL_PEND] = st_reg.pending;
      end
    end

    // Register writes through the low byte lane.
    if (req && wb_we_i && wb_sel_i[0])
    begin
      if (idx == mtx_pkg::IDX_CFG)
      begin
        st_next.cfg = wb_dat_i[7:0] & mtx_pkg::CFG_MASK;
      end
      else if (idx == mtx_pkg::IDX_DCFG)
      begin
        st_next.loop_select_n = wb_dat_i[mtx_pkg::DCFG_LS];
      end
      else if (idx == mtx_pkg::IDX_CTRL)
      begin
        if (wb_dat_i[mtx_pkg::CTRL_START] && !st_reg.pending
            && (st_reg.state == mtx_pkg::MTX_IDLE))
        begin
          st_next.pending = 1'b1;
          st_next.status  = 8'h00;
          st_next.ncoll   = 5'h00;
        end
      end
    end

    // Special multicast packets gate the transmitter.
    if (mc_hash_valid && st_next.cfg[mtx_pkg::CFG_ATD])
    begin
      if (mc_hash_index == mtx_pkg::HASH_TX_OFF)
      begin
        st_next.tx_en = 1'b0;
      end
      else if (mc_hash_index == mtx_pkg::HASH_TX_ON)
      begin
        st_next.tx_en = 1'b1;
      end
    end
    if (!st_next.cfg[mtx_pkg::CFG_ATD])
    begin
      st_next.tx_en = 1'b1;
    end

    case (st_reg.state)
      mtx_pkg::MTX_IDLE:
      begin
        if (st_reg.pending && st_reg.tx_en)
        begin
          st_next.pending   = 1'b0;
          st_next.attempt   = 1'b1;
          st_next.attempts  = 5'h01;
          st_next.slot_cnt  = '0;
          st_next.past_slot = 1'b0;
          st_next.state     = mtx_pkg::MTX_SEND;
        end
      end
      mtx_pkg::MTX_SEND:
      begin
        if (slot_tick)
        begin
          st_next.past_slot = 1'b1;
        end
        if (!carrier_sense)
        begin
          st_next.status[mtx_pkg::ST_CRS] = 1'b1;
        end
        if (eng_underrun)
        begin
          st_next.status[mtx_pkg::ST_FU] = 1'b1;
          st_next.abort = 1'b1;
          st_next.state = mtx_pkg::MTX_IDLE;
        end
        else if (eng_collision)
        begin
          st_next.status[mtx_pkg::ST_COL] = 1'b1;
          if (st_reg.ncoll != 5'h1F)
          begin
            st_next.ncoll = st_reg.ncoll + 5'h01;
          end
          if (st_reg.past_slot)
          begin
            st_next.status[mtx_pkg::ST_OWC] = 1'b1;
          end
          if (st_reg.attempts == ATT_MAX)
          begin
            st_next.status[mtx_pkg::ST_ABT] = 1'b1;
            st_next.abort = 1'b1;
            st_next.state = mtx_pkg::MTX_IDLE;
          end
          else
          begin
            bo_load          = 1'b1;
            st_next.slot_cnt = '0;
            st_next.state    = mtx_pkg::MTX_BACKOFF;
          end
        end
        else if (eng_done)
        begin
          st_next.status[mtx_pkg::ST_SENT] = 1'b1;
          hb_load         = 1'b1;
          st_next.cd_seen = 1'b0;
          st_next.state   = mtx_pkg::MTX_HEART;
        end
      end
      mtx_pkg::MTX_BACKOFF:
      begin
        if (bo_zero)
        begin
          st_next.attempt   = 1'b1;
          st_next.attempts  = st_reg.attempts + 5'h01;
          st_next.slot_cnt  = '0;
          st_next.past_slot = 1'b0;
          st_next.state     = mtx_pkg::MTX_SEND;
        end
      end
      mtx_pkg::MTX_HEART:
      begin
        if (cd_heartbeat)
        begin
          st_next.cd_seen = 1'b1;
        end
        if (hb_zero)
        begin
          if (!st_reg.cd_seen && !cd_heartbeat)
          begin
            st_next.status[mtx_pkg::ST_CDH] = 1'b1;
          end
          st_next.state = mtx_pkg::MTX_IDLE;
        end
      end
      default:
      begin
        st_next.state = mtx_pkg::MTX_IDLE;
      end
    endcase

    // Reserved status bit is held at zero.
    st_next.status[1] = 1'b0;

    // Configuration decoded into registered controls.
    st_next.crc_app   = !st_next.cfg[mtx_pkg::CFG_CRC_INH];
    st_next.codec_pin = (st_next.cfg[mtx_pkg::CFG_LB_HI:mtx_pkg::CFG_LB_LO]
                         == mtx_pkg::MTX_LB_CODEC);
    st_next.lb_active = !st_next.loop_select_n;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg               <= '0;
      st_reg.state         <= mtx_pkg::MTX_IDLE;
      st_reg.cfg           <= mtx_pkg::CFG_RESET;
      st_reg.status        <= mtx_pkg::STATUS_RESET;
      st_reg.loop_select_n <= mtx_pkg::DCFG_LS_RESET;
      st_reg.tx_en         <= 1'b1;
      st_reg.crc_app       <= 1'b1;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign wb_dat_o        = st_reg.dat;
  assign wb_ack_o        = st_reg.ack;
  assign tx_attempt      = st_reg.attempt;
  assign tx_abort        = st_reg.abort;
  assign crc_append      = st_reg.crc_app;
  assign loop_mode       = st_reg.cfg[mtx_pkg::CFG_LB_HI:mtx_pkg::CFG_LB_LO];
  assign codec_loop_pin  = st_reg.codec_pin;
  assign loopback_active = st_reg.lb_active;
  assign tx_enabled      = st_reg.tx_en;

endmodule
`default_nettype wire

/* include/mtx_pkg.sv */
package mtx_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int HB_WINDOW_NS  = 6400;
  localparam int HB_CYCLES     = HB_WINDOW_NS / CLK_PERIOD_NS;
  localparam int SLOT_NS       = 51200;
  localparam int SLOT_CYCLES   = SLOT_NS / CLK_PERIOD_NS;
  localparam int MAX_ATTEMPTS  = 16;
  localparam int PRIO_COLLS    = 3;
  localparam int PRIO_ADD      = 3;
  localparam int BACKOFF_CAP   = 10;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [5:0] IDX_STATUS = 6'h04;
  localparam logic [5:0] IDX_NCOLL  = 6'h05;
  localparam logic [5:0] IDX_CFG    = 6'h0D;
  localparam logic [5:0] IDX_DCFG   = 6'h0E;
  localparam logic [5:0] IDX_CTRL   = 6'h10;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int CFG_CRC_INH = 0;
  localparam int CFG_LB_LO   = 1;
  localparam int CFG_LB_HI   = 2;
  localparam int CFG_ATD     = 3;
  localparam int CFG_PRIORITY_BACKOFF_ENABLE    = 4;
  localparam logic [7:0] CFG_MASK  = 8'h1F;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int ST_SENT = 0;
  localparam int ST_COL  = 2;
  localparam int ST_ABT  = 3;
  localparam int ST_CRS  = 4;
  localparam int ST_FU   = 5;
  localparam int ST_CDH  = 6;
  localparam int ST_OWC  = 7;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int DCFG_LS = 3;
  localparam logic DCFG_LS_RESET = 1'b1;
  localparam int CTRL_START = 0;
  localparam int CTRL_BUSY  = 0;
  localparam int CTRL_EN    = 1;
  localparam int CTRL_PEND  = 2;
  localparam logic [5:0] HASH_TX_OFF = 6'h3E;
  localparam logic [5:0] HASH_TX_ON  = 6'h3F;
  localparam logic [15:0] LFSR_SEED  = 16'hACE1;

  typedef enum logic [1:0] {
    MTX_LB_NORMAL = 2'h0,
    MTX_LB_CORE   = 2'h1,
    MTX_LB_CODEC  = 2'h2,
    MTX_LB_EXT    = 2'h3
  } mtx_lb_t;

  typedef enum logic [3:0] {
    MTX_IDLE    = 4'h1,
    MTX_SEND    = 4'h2,
    MTX_BACKOFF = 4'h4,
    MTX_HEART   = 4'h8
  } mtx_state_t;

endpackage

/* verilog/mtx_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module mtx_timer #(
  parameter int W = 10
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         tick,
  output logic              zero
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } mtx_tmr_t;

  mtx_tmr_t tmr_reg;
  mtx_tmr_t tmr_next;

  // ----------------------------------------------------------------------
  // Down counter
  // ----------------------------------------------------------------------
  always_comb
  begin
    tmr_next = tmr_reg;
    if (load)
    begin
      tmr_next.cnt = load_val;
    end
    else if (tick && (tmr_reg.cnt != '0))
    begin
      tmr_next.cnt = tmr_reg.cnt - W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tmr_reg <= '0;
    end
    else
    begin
      tmr_reg <= tmr_next;
    end
  end

  assign zero = (tmr_reg.cnt == '0);

endmodule
`default_nettype wire

/* verilog/mtx_backoff.sv */
`timescale 1ns/100ps
`default_nettype none
module mtx_backoff (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] coll_num,
  input  wire logic       prio_en,
  output logic      [9:0] slots
);

  typedef struct packed {
    logic [15:0] lfsr;
  } mtx_bo_t;

  mtx_bo_t bo_reg;
  mtx_bo_t bo_next;
  int      expo;
  logic [9:0] mask;

  // ----------------------------------------------------------------------
  // Free running random source
  // ----------------------------------------------------------------------
  always_comb
  begin
    bo_next = bo_reg;
    bo_next.lfsr = {bo_reg.lfsr[14:0],
                    bo_reg.lfsr[15] ^ bo_reg.lfsr[13]
                    ^ bo_reg.lfsr[12] ^ bo_reg.lfsr[10]};
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bo_reg <= '{lfsr: mtx_pkg::LFSR_SEED};
    end
    else
    begin
      bo_reg <= bo_next;
    end
  end

  // ----------------------------------------------------------------------
  // Range of the draw
  // ----------------------------------------------------------------------
  always_comb
  begin
    expo = int'(coll_num);
    if (prio_en && (expo <= mtx_pkg::PRIO_COLLS))
    begin
      expo = expo + mtx_pkg::PRIO_ADD;
    end
    if (expo > mtx_pkg::BACKOFF_CAP)
    begin
      expo = mtx_pkg::BACKOFF_CAP;
    end
    for (int i = 0; i < 10; i++)
    begin
      mask[i] = (i < expo);
    end
    slots = bo_reg.lfsr[9:0] & mask;
  end

endmodule
`default_nettype wire

/* verification/mtx_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for the transmit configuration and status block.
// ----------------------------------------------------------------------
module mtx_top_checker #(
  parameter int SLOT_CYCLES = 6
) (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        eng_done,
  input wire logic        eng_collision,
  input wire logic        eng_underrun,
  input wire logic        carrier_sense,
  input wire logic        cd_heartbeat,
  input wire logic        mc_hash_valid,
  input wire logic [5:0]  mc_hash_index,
  input wire logic        tx_attempt,
  input wire logic        tx_abort,
  input wire logic        crc_append,
  input wire logic [1:0]  loop_mode,
  input wire logic        codec_loop_pin,
  input wire logic        loopback_active,
  input wire logic        tx_enabled
);
  localparam int STD_MAX  = 2 * SLOT_CYCLES + 6;
  localparam int PRIO_MAX = 16 * SLOT_CYCLES + 6;
  logic       atd_reg;
  logic       prio_reg;
  logic       und_reg;
  logic [4:0] att_reg;
  logic [4:0] col_reg;
  logic       wr_ack;
  assign wr_ack = wb_ack_o && wb_we_i && wb_sel_i[0];
  // Mirrors of the configuration and of the attempts since the last start.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      atd_reg  <= 1'b0;
      prio_reg <= 1'b0;
      und_reg  <= 1'b0;
      att_reg  <= 5'h00;
      col_reg  <= 5'h00;
    end
    else
    begin
      if (tx_attempt)
        att_reg <= att_reg + 5'h01;
      if (eng_collision)
        col_reg <= col_reg + 5'h01;
      if (eng_underrun)
        und_reg <= 1'b1;
      if (wr_ack && wb_adr_i == 8'h34)
      begin
        atd_reg  <= wb_dat_i[3];
        prio_reg <= wb_dat_i[4];
      end
      if (wr_ack && wb_adr_i == 8'h40 && wb_dat_i[0])
      begin
        att_reg <= 5'h00;
        col_reg <= 5'h00;
        und_reg <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  codec_pin_a: assert property (
    codec_loop_pin == (loop_mode == 2'h2)) else $error("loop pin wrong");
  cfg_write_a: assert property (
    wr_ack && wb_adr_i == 8'h34 |=> crc_append == !$past(wb_dat_i[0])
    && loop_mode == $past(wb_dat_i[2:1])) else $error("config not applied");
  loop_sel_a: assert property (
    wr_ack && wb_adr_i == 8'h38 |=> loopback_active == !$past(wb_dat_i[3]))
    else $error("loop select wrong");
  hash_off_a: assert property (
    mc_hash_valid && mc_hash_index == 6'h3E && atd_reg |=> !tx_enabled)
    else $error("transmitter not disabled");
  hash_on_a: assert property (
    mc_hash_valid && mc_hash_index == 6'h3F && atd_reg |=> tx_enabled)
    else $error("transmitter not enabled");
  atd_clear_a: assert property (
    $fell(atd_reg) |-> ##[0:2] tx_enabled) else $error("no re-enable");
  std_backoff_a: assert property (
    eng_collision && col_reg == 5'h00 && !prio_reg |-> ##[1:STD_MAX]
    tx_attempt) else $error("standard backoff too long");
  prio_backoff_a: assert property (
    eng_collision && col_reg == 5'h00 && prio_reg |-> ##[1:PRIO_MAX]
    tx_attempt) else $error("priority backoff too long");
  underrun_abort_a: assert property (
    eng_underrun |-> ##[1:3] tx_abort) else $error("underrun not aborted");
  retry_limit_a: assert property (
    tx_abort && !und_reg |-> att_reg == 5'h10) else $error("abort count");
endmodule
bind mtx_top mtx_top_checker #(.SLOT_CYCLES(SLOT_CYCLES)) i_mtx_top_checker (.*);
`default_nettype wire

/* verification/mtx_phy_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Transmit engine and transceiver model; mode picks the outcome.
// ----------------------------------------------------------------------
module mtx_phy_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       tx_attempt,
  input  wire logic [3:0] mode,
  input  wire logic [7:0] dly,
  output logic            eng_done,
  output logic            eng_collision,
  output logic            eng_underrun,
  output logic            carrier_sense,
  output logic            cd_heartbeat
);
  logic       busy;
  logic       hit;
  logic [7:0] cnt;
  logic [3:0] hb;
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {busy, hit, eng_done, eng_collision, eng_underrun} <= 5'h00;
      {carrier_sense, cd_heartbeat, cnt, hb} <= 14'h2000;
    end
    else
    begin
      {eng_done, eng_collision, eng_underrun} <= 3'h0;
      carrier_sense <= !(busy && mode[2] && cnt == 8'h02);
      cd_heartbeat  <= (hb == 4'h1);
      cnt           <= cnt + 8'h01;
      if (hb != 4'h0)
        hb <= hb - 4'h1;
      if (tx_attempt)
      begin
        busy <= 1'b1;
        cnt  <= 8'h00;
      end
      else if (busy && cnt == dly)
      begin
        busy <= 1'b0;
        if (mode[1:0] == 2'h2)
          eng_underrun <= 1'b1;
        else if (mode[1:0] == 2'h3 || (mode[1:0] == 2'h1 && !hit))
          {eng_collision, hit} <= 2'h3;
        else
          {eng_done, hit, hb} <= {2'h2, mode[3] ? 4'h0 : 4'h6};
      end
    end
  end
endmodule
`default_nettype wire

/* verification/mtx_top_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module mtx_top_bench;
  logic        sys_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i, dly, rd;
  logic [3:0]  wb_sel_i, mode;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        eng_done, eng_collision, eng_underrun, carrier_sense;
  logic        cd_heartbeat, mc_hash_valid, tx_attempt, tx_abort;
  logic        crc_append, codec_loop_pin, loopback_active, tx_enabled;
  logic [5:0]  mc_hash_index;
  logic [1:0]  loop_mode;
  int          err_total = 0, checks = 0, n_att = 0, n_abt = 0, base;
  mtx_top #(.SLOT_CYCLES(6)) i_mtx_top (.*);
  mtx_phy_model i_mtx_phy_model (.*);
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    n_att <= n_att + int'(tx_attempt === 1'b1);
    n_abt <= n_abt + int'(tx_abort === 1'b1);
  end
  // --------------------------------------------------------------------
  // Bus, compare and scenario tasks.
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, we, a};
    wb_dat_i <= {24'h000000, d};
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o[7:0];
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
    chk({31'h0, wb_ack_o}, 32'h1);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    wb(1'b0, a, 8'h00);
    chk({24'h0, rd}, {24'h0, exp});
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      repeat (8) @(posedge sys_clk);
      wb(1'b0, 8'h40, 8'h00);
      n++;
    end
    while ((rd[0] | rd[2]) !== 1'b0 && n < 5000);
    chk({31'h0, rd[0] | rd[2]}, 32'h0);
  endtask
  task automatic send(input logic [3:0] m, input logic [7:0] d,
                      input logic [7:0] st, input logic [7:0] nc);
    mode <= m;
    dly  <= d;
    wb(1'b1, 8'h40, 8'h01);
    wait_idle();
    rdchk(8'h10, st);
    rdchk(8'h14, nc);
    $display("transmit test with mode %h done", m);
  endtask
  task automatic hash(input logic [5:0] h);
    @(posedge sys_clk);
    {mc_hash_valid, mc_hash_index} <= {1'b1, h};
    @(posedge sys_clk);
    mc_hash_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #900000;
    err_total++;
    $display("Error at %0t: watchdog expired", $time);
    finish_test();
  end
  initial
  begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, mc_hash_valid} = 5'h00;
    {wb_adr_i, wb_dat_i, wb_sel_i, mc_hash_index} = 50'h0;
    wb_sel_i = 4'hF;
    {mode, dly} = 12'h00A;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk(32'({crc_append, loop_mode, codec_loop_pin, tx_enabled}), 32'h11);
    chk({31'h0, loopback_active}, 32'h0);
    rdchk(8'h38, 8'h08);
    rdchk(8'h7C, 8'h00);
    wb(1'b1, 8'h38, 8'h00);
    @(posedge sys_clk);
    chk({31'h0, loopback_active}, 32'h1);
    for (int i = 0; i < 8; i++)
    begin
      wb(1'b1, 8'h34, {5'b11100, i[2:0]});
      @(posedge sys_clk);
      chk(32'({crc_append, loop_mode, codec_loop_pin}),
          32'({!i[0], i[2:1], i[2:1] == 2'h2}));
    end
    rdchk(8'h34, 8'h00);
    wb(1'b1, 8'h38, 8'h08);
    wb(1'b1, 8'h34, 8'h00);
    $display("configuration test done");
    send(4'h0, 8'd10, 8'h01, 8'h00);
    wb(1'b1, 8'h34, 8'h10);
    send(4'h9, 8'd2, 8'h45, 8'h01);
    wb(1'b1, 8'h34, 8'h00);
    send(4'h1, 8'd20, 8'h85, 8'h01);
    send(4'h4, 8'd10, 8'h11, 8'h00);
    send(4'h2, 8'd10, 8'h20, 8'h00);
    send(4'h3, 8'd0, 8'h0C, 8'h10);
    chk(32'(n_abt), 32'h2);
    send(4'h0, 8'd10, 8'h01, 8'h00);
    hash(6'h3E);
    chk({31'h0, tx_enabled}, 32'h1);
    wb(1'b1, 8'h34, 8'h08);
    hash(6'h3E);
    chk({31'h0, tx_enabled}, 32'h0);
    hash(6'h3F);
    chk({31'h0, tx_enabled}, 32'h1);
    hash(6'h3E);
    base = n_att;
    wb(1'b1, 8'h40, 8'h01);
    repeat (20) @(posedge sys_clk);
    chk(32'(n_att - base), 32'h0);
    wb(1'b1, 8'h34, 8'h00);
    repeat (6) @(posedge sys_clk);
    chk({31'h0, tx_enabled}, 32'h1);
    chk(32'(n_att - base), 32'h1);
    wait_idle();
    rdchk(8'h10, 8'h01);
    $display("auto disable test done");
    finish_test();
  end
endmodule
`default_nettype wire
